/* hw/dcw3_top.sv */
/*
 * dcw3_top: captures the third configuration word at reset release,
 * drives the static pin and mode selections and serves a read-only
 * ahb-lite view. assumes the non-volatile word is stable on i_nv_word
 * around reset release and one clock domain i_sys_clk.
 */
// Local design decisions: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
// Behaviour
// - bit 31 high gives the bus power pin to usb, low to port logic
// - bit 30 high gives the usb id pin to usb, low to port logic
// - bit 26 high picks default can pins, low alternate pins
// - bit 25 high picks default ethernet pins, low alternate pins
// - bit 24 high selects full mii, low selects reduced rmii
// - bits 18-16 name the shadow set priority, zero means levels 1 to 7
// - low sixteen bits are a user id readable by programming and jtag
// - absent can or ethernet make their select bits read as one
module dcw3_top #(
    parameter bit HAS_CAN = 1'b1,
    parameter bit HAS_ETH = 1'b1
) (
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_rst_n,
    input  wire logic [31:0]             i_nv_word,
    input  wire logic                    i_hsel,
    input  wire logic [31:0]             i_haddr,
    input  wire logic [1:0]              i_htrans,
    input  wire logic                    i_hwrite,
    input  wire logic [2:0]              i_hsize,
    input  wire logic [31:0]             i_hwdata,
    input  wire logic                    i_hready,
    output logic [31:0]                  o_hrdata,
    output logic                         o_hreadyout,
    output logic                         o_hresp,
    output logic                         o_bus_power_pin_usb,
    output logic                         o_usb_id_pin_usb,
    output logic                         o_can_default_pins,
    output logic                         o_eth_default_pins,
    output logic                         o_eth_mii_mode,
    output logic [2:0]                   o_shadow_set_priority_sel,
    output logic [7:0]                   o_shadow_level_mask,
    output logic [15:0]                  o_user_identifier,
    output logic                         o_rsvd_bits_ok,
    output logic                         o_word_valid
);
    import dcw3_pkg::*;

    typedef enum logic [1:0] {
        DCW3_ST_LOAD = 2'b01,
        DCW3_ST_HOLD = 2'b10
    } dcw3_state_t;

    dcw3_state_t       state_q, state_d;
    logic [31:0]       word_q, word_d;
    logic              rd_pend_q, rd_pend_d;
    logic [ADDR_W-1:0] rd_addr_q, rd_addr_d;
    logic [31:0]       rdata_q, rdata_d;
    dcw3_sel_t         sel_dec;
    dcw3_ahb_req_t     req;
    logic [31:0]       word_view;
    logic              rsvd_ok;

    dcw3_field_dec #(
        .HAS_CAN (HAS_CAN),
        .HAS_ETH (HAS_ETH)
    ) u_dec (
        .i_word (word_q),
        .o_sel  (sel_dec)
    );

    // capture: first clock after release loads once, then frozen
    always_comb begin
        state_d = state_q;
        word_d  = word_q;
        case (state_q)
            DCW3_ST_LOAD: begin
                word_d  = i_nv_word;
                state_d = DCW3_ST_HOLD;
            end
            DCW3_ST_HOLD: begin
                word_d = word_q;
            end
            default: begin
                state_d = DCW3_ST_LOAD;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= DCW3_ST_LOAD;
            word_q  <= WORD_RESET;
        end else begin
            state_q <= state_d;
            word_q  <= word_d;
        end
    end

    // reserved groups are only checked, a wrong programmer shows here
    assign rsvd_ok = &word_q[RSVD_HI_MSB:RSVD_HI_LSB] &
                     &word_q[RSVD_LO_MSB:RSVD_LO_LSB];

    // word as read back, with absent peripheral bits forced high
    always_comb begin
        word_view = word_q;
        word_view[CAN_SET_BIT] = sel_dec.can_pin_set_sel;
        word_view[ETH_SET_BIT] = sel_dec.eth_pin_set_sel;
        word_view[MII_EN_BIT]  = sel_dec.full_phy_iface_enable;
    end

    // ahb-lite slave, read only; writes are accepted and dropped so
    // software cannot move any selection
    always_comb begin
        req.sel   = i_hsel;
        req.trans = i_htrans;
        req.write = i_hwrite;
        req.ready = i_hready;
        req.addr  = i_haddr[ADDR_W-1:0];
    end

    always_comb begin
        rd_pend_d = 1'b0;
        rd_addr_d = rd_addr_q;
        rdata_d   = rdata_q;
        if (req.sel && req.ready && req.trans[1] && !req.write) begin
            rd_pend_d = 1'b1;
            rd_addr_d = req.addr;
        end
        if (rd_pend_q) begin
            case (rd_addr_q)
                ADDR_WORD:   rdata_d = word_view;
                ADDR_STATUS: rdata_d = {30'h0, rsvd_ok,
                                        state_q == DCW3_ST_HOLD};
                ADDR_DECODE: rdata_d = {8'h0, sel_dec.shadow_level_mask,
                                        sel_dec.user_identifier};
                default:     rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_pend_q <= 1'b0;
            rd_addr_q <= '0;
            rdata_q   <= 32'h0;
        end else begin
            rd_pend_q <= rd_pend_d;
            rd_addr_q <= rd_addr_d;
            rdata_q   <= rdata_d;
        end
    end

    // one wait state in the read data phase lets hrdata come from a flop
    assign o_hreadyout = ~rd_pend_q;
    assign o_hresp     = 1'b0;
    assign o_hrdata    = rdata_q;

    assign o_bus_power_pin_usb       = sel_dec.bus_power_pin_owner_sel;
    assign o_usb_id_pin_usb          = sel_dec.usb_id_pin_owner_sel;
    assign o_can_default_pins        = sel_dec.can_pin_set_sel;
    assign o_eth_default_pins        = sel_dec.eth_pin_set_sel;
    assign o_eth_mii_mode            = sel_dec.full_phy_iface_enable;
    assign o_shadow_set_priority_sel = sel_dec.shadow_set_priority_sel;
    assign o_shadow_level_mask       = sel_dec.shadow_level_mask;
    assign o_user_identifier         = sel_dec.user_identifier;
    assign o_rsvd_bits_ok            = rsvd_ok;
    assign o_word_valid              = (state_q == DCW3_ST_HOLD);
endmodule // dcw3_top

/* shared/dcw3_pkg.sv */
/*
 * dcw3_pkg: constants and carrier types for the third configuration
 * word decoder. assumes nothing beyond a SystemVerilog compiler.
 */
package dcw3_pkg;
    // word bit positions
    localparam int BUS_POWER_BIT  = 31;
    localparam int USB_ID_BIT     = 30;
    localparam int RSVD_HI_MSB    = 29;
    localparam int RSVD_HI_LSB    = 27;
    localparam int CAN_SET_BIT    = 26;
    localparam int ETH_SET_BIT    = 25;
    localparam int MII_EN_BIT     = 24;
    localparam int RSVD_LO_MSB    = 23;
    localparam int RSVD_LO_LSB    = 19;
    localparam int SRS_MSB        = 18;
    localparam int SRS_LSB        = 16;
    localparam int USER_ID_MSB    = 15;
    localparam int USER_ID_LSB    = 0;
    // erased value, also the reset value of the captured word
    localparam logic [31:0] WORD_RESET = 32'hffff_ffff;
    // ahb register map, byte addresses
    localparam logic [7:0] ADDR_WORD   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_DECODE = 8'h08;
    localparam int ADDR_W = 8;
    // shadow set code that hands every level except level 0 to a shadow set
    localparam logic [2:0] SRS_ALL_CODE = 3'h0;

    typedef struct packed {
        logic       bus_power_pin_owner_sel;
        logic       usb_id_pin_owner_sel;
        logic       can_pin_set_sel;
        logic       eth_pin_set_sel;
        logic       full_phy_iface_enable;
        logic [2:0] shadow_set_priority_sel;
        logic [7:0] shadow_level_mask;
        logic [15:0] user_identifier;
    } dcw3_sel_t;

    typedef struct packed {
        logic        sel;
        logic [1:0]  trans;
        logic        write;
        logic        ready;
        logic [ADDR_W-1:0] addr;
    } dcw3_ahb_req_t;
endpackage

/* hw/dcw3_field_dec.sv */
/*
 * dcw3_field_dec: combinational decode of one raw configuration word
 * into the selection struct. assumes the word is already held stable.
 */
`timescale 1ns/1ps
module dcw3_field_dec #(
    parameter bit HAS_CAN = 1'b1,
    parameter bit HAS_ETH = 1'b1
) (
    input  wire logic [31:0]        i_word,
    output dcw3_pkg::dcw3_sel_t     o_sel
);
    import dcw3_pkg::*;

    logic [2:0] srs;

    always_comb begin
        srs = i_word[SRS_MSB:SRS_LSB];
        o_sel.bus_power_pin_owner_sel = i_word[BUS_POWER_BIT];
        o_sel.usb_id_pin_owner_sel    = i_word[USB_ID_BIT];
        // missing peripherals force their bits high
        o_sel.can_pin_set_sel = HAS_CAN ? i_word[CAN_SET_BIT]
                                        : 1'b1;
        o_sel.eth_pin_set_sel = HAS_ETH ? i_word[ETH_SET_BIT]
                                        : 1'b1;
        o_sel.full_phy_iface_enable = HAS_ETH ? i_word[MII_EN_BIT]
                                              : 1'b1;
        o_sel.shadow_set_priority_sel = srs;
        // bit n set: priority level n uses a shadow set
        if (srs == SRS_ALL_CODE) begin
            o_sel.shadow_level_mask = 8'hfe;
        end else begin
            o_sel.shadow_level_mask = 8'h01 << srs;
        end
        o_sel.user_identifier = i_word[USER_ID_MSB:USER_ID_LSB];
    end
endmodule // dcw3_field_dec

/* verification/dcw3_top_properties.sv */
/* dcw3_top_properties: assertions on the decoded selections of dcw3_top.
   assumes i_nv_word is held steady from reset until the capture edge. */
`timescale 1ns/1ps
module dcw3_top_properties #(
    parameter bit HAS_CAN = 1'b1,
    parameter bit HAS_ETH = 1'b1
) (
    input wire logic        i_sys_clk,
    input wire logic        i_rst_n,
    input wire logic [31:0] i_nv_word,
    input wire logic        o_bus_power_pin_usb,
    input wire logic        o_usb_id_pin_usb,
    input wire logic        o_can_default_pins,
    input wire logic        o_eth_default_pins,
    input wire logic        o_eth_mii_mode,
    input wire logic [2:0]  o_shadow_set_priority_sel,
    input wire logic [7:0]  o_shadow_level_mask,
    input wire logic [15:0] o_user_identifier,
    input wire logic        o_word_valid
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // capture edge is the one before valid rises, so $past sees the word
    property p_bus_power; $rose(o_word_valid) |->
        o_bus_power_pin_usb == $past(i_nv_word[31]); endproperty
    a_bus_power: assert property (p_bus_power)
        else $error("bus power owner wrong");
    property p_usb_id; $rose(o_word_valid) |->
        o_usb_id_pin_usb == $past(i_nv_word[30]); endproperty
    a_usb_id: assert property (p_usb_id)
        else $error("usb id owner wrong");
    property p_can_set; $rose(o_word_valid) |->
        o_can_default_pins == (HAS_CAN ? $past(i_nv_word[26]) : 1'b1);
    endproperty
    a_can_set: assert property (p_can_set)
        else $error("can pin set wrong");
    property p_eth_set; $rose(o_word_valid) |->
        o_eth_default_pins == (HAS_ETH ? $past(i_nv_word[25]) : 1'b1);
    endproperty
    a_eth_set: assert property (p_eth_set)
        else $error("eth pin set wrong");
    property p_mii; $rose(o_word_valid) |->
        o_eth_mii_mode == (HAS_ETH ? $past(i_nv_word[24]) : 1'b1);
    endproperty
    a_mii: assert property (p_mii)
        else $error("phy mode wrong");
    property p_shadow; o_shadow_level_mask ==
        ((o_shadow_set_priority_sel == 3'h0) ? 8'hfe
        : (8'h01 << o_shadow_set_priority_sel)); endproperty
    a_shadow: assert property (p_shadow)
        else $error("shadow mask wrong");
    property p_user_id; $rose(o_word_valid) |->
        o_user_identifier == $past(i_nv_word[15:0]); endproperty
    a_user_id: assert property (p_user_id)
        else $error("user id wrong");
    property p_hold; o_word_valid |=> $stable({o_bus_power_pin_usb,
        o_usb_id_pin_usb, o_can_default_pins, o_eth_default_pins,
        o_eth_mii_mode, o_shadow_level_mask, o_user_identifier}); endproperty
    a_hold: assert property (p_hold)
        else $error("selection changed");
endmodule // dcw3_top_properties
bind dcw3_top dcw3_top_properties #(.HAS_CAN(HAS_CAN), .HAS_ETH(HAS_ETH))
    u_props (.i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n), .i_nv_word(i_nv_word),
    .o_bus_power_pin_usb(o_bus_power_pin_usb),
    .o_usb_id_pin_usb(o_usb_id_pin_usb),
    .o_can_default_pins(o_can_default_pins),
    .o_eth_default_pins(o_eth_default_pins),
    .o_eth_mii_mode(o_eth_mii_mode),
    .o_shadow_set_priority_sel(o_shadow_set_priority_sel),
    .o_shadow_level_mask(o_shadow_level_mask),
    .o_user_identifier(o_user_identifier), .o_word_valid(o_word_valid));

/* verification/test_device_config_word_three_decode.sv */
/* test_device_config_word_three_decode: table of words, then hold, write,
   unmapped and reset cases. uses dcw3_top with default parameters, plus a second instance with no can and no ethernet. */
`timescale 1ns/1ps
module test_device_config_word_three_decode;
    import dcw3_pkg::*;
    typedef struct packed {logic [31:0] w; logic [7:0] m;} dcw3_row_t;
    logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] nv = WORD_RESET, haddr = '0, hwdata = '0, hrdata, rd, d;
    logic [1:0]  htrans = 2'h0;
    logic        hreadyout, hresp, bp, uid, can, eth, mii, rok, valid, rdy;
    logic [2:0]  ssel;
    logic [7:0]  mask;
    logic [15:0] user;
    logic        can2, eth2, mii2;
    int          errors = 0, tests_run = 0;
    dcw3_row_t   r;
    dcw3_row_t   rows [8] = '{'{32'hbaf8_0000, 8'hfe}, '{32'h79f9_a5a5, 8'h02},
        '{32'hfcfa_ffff, 8'h04}, '{32'h3bfb_0001, 8'h08},
        '{32'hfffc_8000, 8'h10}, '{32'h38fd_1234, 8'h20},
        '{32'h87fe_4321, 8'h40}, '{32'hff07_beef, 8'h80}};
    dcw3_top DUT (.i_sys_clk(clk), .i_rst_n(rst_n), .i_nv_word(nv),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout),
        .o_hresp(hresp), .o_bus_power_pin_usb(bp), .o_usb_id_pin_usb(uid),
        .o_can_default_pins(can), .o_eth_default_pins(eth),
        .o_eth_mii_mode(mii), .o_shadow_set_priority_sel(ssel),
        .o_shadow_level_mask(mask), .o_user_identifier(user),
        .o_rsvd_bits_ok(rok), .o_word_valid(valid));
    // variant with no can and no ethernet, pins only
    dcw3_top #(.HAS_CAN(1'b0), .HAS_ETH(1'b0)) DUT2 (.i_sys_clk(clk),
        .i_rst_n(rst_n), .i_nv_word(nv), .i_hsel(1'b0), .i_haddr(32'h0),
        .i_htrans(2'h0), .i_hwrite(1'b0), .i_hsize(3'h2),
        .i_hwdata(32'h0), .i_hready(1'b1), .o_hrdata(), .o_hreadyout(),
        .o_hresp(), .o_bus_power_pin_usb(), .o_usb_id_pin_usb(),
        .o_can_default_pins(can2), .o_eth_default_pins(eth2),
        .o_eth_mii_mode(mii2), .o_shadow_set_priority_sel(),
        .o_shadow_level_mask(), .o_user_identifier(),
        .o_rsvd_bits_ok(), .o_word_valid());
    always #10 clk = ~clk;
    // bus outputs move only at rising edges, so mid-cycle copies are safe
    always @(negedge clk) begin
        rdy = hreadyout;
        rd = hrdata;
    end
    task automatic chk(input string n, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic report_and_stop;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic ahb(input logic [7:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (!rdy);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (!rdy);
        q = rd;
    endtask
    initial begin
        #20us;
        errors++;
        report_and_stop();
    end
    initial begin
        foreach (rows[i]) begin
            r = rows[i];
            @(posedge clk);
            rst_n <= 1'b0;
            nv <= r.w;
            repeat (5) @(posedge clk);
            rst_n <= 1'b1;
            repeat (2) @(negedge clk);
            chk("bus_power", 32'(r.w[31]), 32'(bp));
            chk("usb_id", 32'(r.w[30]), 32'(uid));
            chk("can_set", 32'(r.w[26]), 32'(can));
            chk("eth_set", 32'(r.w[25]), 32'(eth));
            chk("mii", 32'(r.w[24]), 32'(mii));
            chk("can_absent", 32'h1, 32'(can2));
            chk("eth_absent", 32'h1, 32'(eth2));
            chk("mii_absent", 32'h1, 32'(mii2));
            chk("shadow", 32'(r.w[18:16]), 32'(ssel));
            chk("mask", 32'(r.m), 32'(mask));
            chk("rsvd", 32'(&r.w[29:27] & &r.w[23:19]), 32'(rok));
            ahb(ADDR_WORD, 1'b0, 32'h0, d);
            chk("word", r.w, d);
            ahb(ADDR_STATUS, 1'b0, 32'h0, d);
            chk("status", {30'h0, &r.w[29:27] & &r.w[23:19], 1'b1}, d);
            ahb(ADDR_DECODE, 1'b0, 32'h0, d);
            chk("decode", {8'h0, r.m, r.w[15:0]}, d);
        end
        // software write and a moving source must both leave the word alone
        nv <= 32'h0;
        ahb(ADDR_WORD, 1'b1, 32'h0, d);
        ahb(ADDR_WORD, 1'b0, 32'h0, d);
        chk("hold_word", r.w, d);
        chk("hold_user", 32'(r.w[15:0]), 32'(user));
        ahb(8'h0c, 1'b0, 32'h0, d);
        chk("unmapped", 32'h0, d);
        chk("resp", 32'h0, 32'(hresp));
        @(posedge clk);
        rst_n <= 1'b0;
        @(negedge clk);
        chk("rst_valid", 32'h0, 32'(valid));
        chk("rst_mask", 32'h80, 32'(mask));
        report_and_stop();
    end
endmodule // test_device_config_word_three_decode
